// ### hw/acc_consts.svh
// offsets, field positions, reset values and counts for the comparator
// control; included by the package user files, definitions only
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH
// register offsets on the 3-bit byte address
`define ACC_OFF_CTRL 3'h0
`define ACC_OFF_MUX 3'h2
`define ACC_OFF_IEN 3'h6
`define ACC_OFF_STAT 3'h7
// comparator_control fields
`define ACC_CTRL_EN 0
`define ACC_CTRL_HYS 2:1
`define ACC_CTRL_EDGE 5:4
`define ACC_CTRL_PIN_OUTPUT_ENABLE 6
`define ACC_CTRL_RUNSTBY 7
`define ACC_CTRL_MASK 8'hf7
// input_select_control fields
`define ACC_MUX_NEG 1:0
`define ACC_MUX_POS 3
`define ACC_MUX_INV 7
`define ACC_MUX_MASK 8'h8b
// irq_enable_control and comparator_status fields
`define ACC_IEN_CMP 0
`define ACC_STAT_CMP 0
`define ACC_STAT_STATE 4
// reset value of every register
`define ACC_RESET 8'h00
// irq_edge_select encodings
`define ACC_EDGE_BOTH 2'h0
`define ACC_EDGE_FALL 2'h2
`define ACC_EDGE_RISE 2'h3
// synchroniser depth
`define ACC_SYNC_STAGES 3
`endif

// ### hw/acc_pkg.sv
// types shared by the comparator control files
// assumes nothing beyond a systemverilog compiler
package acc_pkg;
  // sleep state reported by the power manager
  typedef enum logic [1:0] {
    acc_active,
    acc_idle,
    acc_standby,
    acc_pwrdown
  } acc_sleep_t;
  // settings handed to the analog core
  typedef struct packed {
    logic enable;
    logic [1:0] hysteresis_select;
    logic positive_input_select;
    logic [1:0] negative_input_select;
  } acc_analog_t;
endpackage

// ### hw/acc_sync3.sv
// three-stage synchroniser for the comparator level
// assumes the input is asynchronous to ref_clk_i
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_sync3
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic async_i,
  output logic level_o,
  output logic agree_o
);
  // shift chain; stage 0 is read only by stage 1
  logic [`ACC_SYNC_STAGES-1:0] stage;

  genvar gi;
  generate
    for (gi = 0; gi < `ACC_SYNC_STAGES; gi++)
    begin : g_stage
      // stage 0 takes async_i, each later stage takes the one before it
      always_ff @(posedge ref_clk_i)
      begin
        if (reset_i)
          stage[gi] <= 1'b0;
        else if (gi == 0)
          stage[gi] <= async_i;
        else
          stage[gi] <= stage[(gi == 0) ? 0 : gi - 1];
      end
    end
  endgenerate

  // a change counts once the last two stages agree
  assign level_o = stage[`ACC_SYNC_STAGES-1];
  assign agree_o = stage[`ACC_SYNC_STAGES-1] == stage[`ACC_SYNC_STAGES-2];
endmodule

// ### hw/acc_ctl.sv
// digital control around one voltage comparator
// assumes an analog core that returns one raw compare bit
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_ctl
(
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  input wire acc_pkg::acc_sleep_t sleep_mode_i,
  input wire logic clk_req_other_i,
  input wire logic cmp_raw_i,
  output acc_pkg::acc_analog_t analog_cfg_o,
  output logic event_o,
  output logic pin_out_o,
  output logic pin_oe_n_o,
  output logic irq_o
);
  // true when the access hits the given offset
  function automatic logic hit(input logic [2:0] addr,
                               input logic [2:0] off);
    hit = addr == off;
  endfunction

  // software registers, status state and next-edge values
  logic [7:0] ctrl; // comparator_control
  logic [7:0] mux; // input_select_control
  logic inten; // comparator_irq_bit enable
  logic flag; // comparator interrupt flag
  logic state; // synchronised comparator state
  logic next_flag; // flag after this edge
  logic next_en; // comparator enable after this edge
  logic next_oe; // pin enable after this edge

  // decoded strobes
  logic wr_ctrl;
  logic wr_mux;
  logic wr_ien;
  logic wr_stat;

  // comparator path
  logic cmp_out; // inverted and gated result
  logic sync_level; // last synchroniser stage
  logic sync_agree; // last two stages agree
  logic stat_upd; // status may change this cycle
  logic change; // synchronised output moved
  logic qualify; // change matches the edge field
  logic standby_halt; // standby without run-in-standby

  // field views
  logic [1:0] edge_sel;
  logic run_stby;
  logic out_en;

  assign edge_sel = ctrl[`ACC_CTRL_EDGE];
  assign run_stby = ctrl[`ACC_CTRL_RUNSTBY];
  assign out_en = ctrl[`ACC_CTRL_PIN_OUTPUT_ENABLE];

  // write decode
  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_mux = 1'b0;
    wr_ien = 1'b0;
    wr_stat = 1'b0;
    if (!reg_write_i)
      wr_ctrl = 1'b0;
    else if (hit(reg_addr_i, `ACC_OFF_CTRL))
      wr_ctrl = 1'b1;
    else if (hit(reg_addr_i, `ACC_OFF_MUX))
      wr_mux = 1'b1;
    else if (hit(reg_addr_i, `ACC_OFF_IEN))
      wr_ien = 1'b1;
    else if (hit(reg_addr_i, `ACC_OFF_STAT))
      wr_stat = 1'b1;
  end

  // comparator_control; hysteresis and edge fields stored here
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      ctrl <= `ACC_RESET;
    else if (wr_ctrl)
      ctrl <= reg_wdata_i & `ACC_CTRL_MASK;
  end

  // input_select_control; reserved bits stay zero
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      mux <= `ACC_RESET;
    else if (wr_mux)
      mux <= reg_wdata_i & `ACC_MUX_MASK;
  end

  // interrupt enable
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      inten <= 1'b0;
    else if (wr_ien)
      inten <= reg_wdata_i[`ACC_IEN_CMP];
  end

  // sleep handling; debug halt has no input here at all
  // so it cannot stop or alter anything
  always_comb
  begin
    standby_halt = 1'b0;
    stat_upd = 1'b1;
    case (sleep_mode_i)
      acc_pkg::acc_active:
      begin
        stat_upd = 1'b1;
      end
      acc_pkg::acc_idle:
      begin
        stat_upd = 1'b1;
      end
      acc_pkg::acc_standby:
      begin
        standby_halt = !run_stby;
        // no peripheral clock unless someone else asks
        stat_upd = clk_req_other_i;
      end
      acc_pkg::acc_pwrdown:
      begin
        stat_upd = 1'b0;
      end
      default:
      begin
        stat_upd = 1'b0;
      end
    endcase
  end

  // core and pad enables; software is trusted to set the
  // inputs before enabling and to ignore start-up glitches
  always_comb
  begin
    next_en = ctrl[`ACC_CTRL_EN];
    next_oe = out_en;
    if (sleep_mode_i == acc_pkg::acc_pwrdown)
    begin
      next_en = 1'b0;
      next_oe = 1'b0;
    end
    else if (standby_halt)
    begin
      next_en = 1'b0;
      next_oe = 1'b0;
    end
  end

  // analog settings, registered so the core sees clean levels
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      analog_cfg_o <= '0;
    else
    begin
      analog_cfg_o.enable <= next_en;
      analog_cfg_o.hysteresis_select <= ctrl[`ACC_CTRL_HYS];
      analog_cfg_o.positive_input_select <= mux[`ACC_MUX_POS];
      analog_cfg_o.negative_input_select <= mux[`ACC_MUX_NEG];
    end
  end

  // pad enable, low while the pin is driven
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      pin_oe_n_o <= 1'b1;
    else
      pin_oe_n_o <= !next_oe;
  end

  // the core drives high when positive exceeds negative;
  // invert is applied once here so every consumer sees it
  assign cmp_out = analog_cfg_o.enable
                   & (cmp_raw_i ^ mux[`ACC_MUX_INV]);

  // event and pad paths bypass the clock on purpose: they
  // must keep moving in standby with the clock stopped
  assign event_o = cmp_out;
  assign pin_out_o = cmp_out;

  // bring the result into the clock domain
  acc_sync3 u_sync
  (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .async_i(cmp_out),
    .level_o(sync_level),
    .agree_o(sync_agree)
  );

  // a settled change of the synchronised level
  assign change = sync_agree && (sync_level != state);

  // edge qualification; the reserved code never fires
  always_comb
  begin
    qualify = 1'b0;
    case (edge_sel)
      `ACC_EDGE_BOTH: qualify = change;
      `ACC_EDGE_FALL: qualify = change && !sync_level;
      `ACC_EDGE_RISE: qualify = change && sync_level;
      default: qualify = 1'b0;
    endcase
  end

  // state bit follows the settled level, frozen while the
  // status may not update
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      state <= 1'b0;
    else if (stat_upd && sync_agree)
      state <= sync_level;
  end

  // flag: a set in the same cycle as a clear wins
  always_comb
  begin
    next_flag = flag;
    if (wr_stat && reg_wdata_i[`ACC_STAT_CMP])
      next_flag = 1'b0;
    if (stat_upd && qualify)
      next_flag = 1'b1;
  end

  // interrupt flag register
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      flag <= 1'b0;
    else
      flag <= next_flag;
  end

  // request follows flag and enable from the same edge;
  // it stays up until the flag or the enable goes
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else if (wr_ien)
      irq_o <= next_flag & reg_wdata_i[`ACC_IEN_CMP];
    else
      irq_o <= next_flag & inten;
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
      reg_rdata_o <= 8'h00;
    else if (!reg_read_i)
      reg_rdata_o <= 8'h00;
    else if (hit(reg_addr_i, `ACC_OFF_CTRL))
      reg_rdata_o <= ctrl;
    else if (hit(reg_addr_i, `ACC_OFF_MUX))
      reg_rdata_o <= mux;
    else if (hit(reg_addr_i, `ACC_OFF_IEN))
      reg_rdata_o <= {7'h00, inten};
    else if (hit(reg_addr_i, `ACC_OFF_STAT))
      reg_rdata_o <= {3'h0, state, 3'h0, flag};
    else
      reg_rdata_o <= 8'h00;
  end

  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  // a qualifying rising edge while status may update
  sequence rise_seen;
    stat_upd && change && sync_level
      && edge_sel == `ACC_EDGE_RISE;
  endsequence

  // the gated result held still long enough to settle
  sequence held_four;
    $stable(cmp_out) [*4];
  endsequence

  rise_flag_a:
    assert property (rise_seen |=> flag && state)
    else $error("rising edge did not set flag");

  irq_tie_a:
    assert property (irq_o == (flag && inten))
    else $error("request differs from flag and enable");

  flag_clear_a:
    assert property (wr_stat && reg_wdata_i[0] && !qualify
                     |=> !flag)
    else $error("write of one left flag set");

  flag_hold_a:
    assert property (flag && !(wr_stat && reg_wdata_i[0])
                     |=> flag)
    else $error("flag dropped without a clear");

  state_lag_a:
    assert property (held_four ##1 (stat_upd [*2])
                     |-> state == $past(cmp_out, 2))
    else $error("state bit not following output");

  pwrdown_off_a:
    assert property (sleep_mode_i == acc_pkg::acc_pwrdown
                     |=> !analog_cfg_o.enable && pin_oe_n_o)
    else $error("power-down left core or pad on");

  stby_halt_a:
    assert property (sleep_mode_i == acc_pkg::acc_standby
                     && !run_stby |=> !analog_cfg_o.enable)
    else $error("standby did not halt comparator");

  stby_frozen_a:
    assert property (sleep_mode_i == acc_pkg::acc_standby
                     && !clk_req_other_i && !flag |=> !flag)
    else $error("flag set without peripheral clock");

  event_path_a:
    assert property (event_o == (analog_cfg_o.enable
                     && (cmp_raw_i ^ mux[7])))
    else $error("event output not the gated result");

  reserved_edge_a:
    assert property (edge_sel == 2'h1 && !flag
                     && !(wr_ien || wr_ctrl) |=> !flag)
    else $error("reserved edge code raised flag");

  ctrl_read_a:
    assert property (reg_read_i && reg_addr_i == 3'h0
                     |=> reg_rdata_o == $past(ctrl))
    else $error("control readback wrong");
endmodule

// ### bench/acc_core_model.sv
// behavioural analog core seen by the comparator control
// assumes millivolt levels from the bench and settings from the design
`timescale 1ns/10ps
module acc_core_model
(
  input wire acc_pkg::acc_analog_t cfg_i,
  input wire logic signed [31:0] pos_mv_i,
  input wire logic signed [31:0] neg_mv_i,
  input wire logic signed [31:0] vref_mv_i,
  output logic cmp_o = 1'b0
);
  int neg; // selected negative level
  int hys; // half band of hysteresis
  // a halted core gives no valid level, so it wanders
  always @(cfg_i, pos_mv_i, neg_mv_i, vref_mv_i)
  begin
    // pin or internal reference on the negative side
    if (cfg_i.negative_input_select == 2'h2)
      neg = vref_mv_i;
    else
      neg = neg_mv_i;
    case (cfg_i.hysteresis_select)
      2'h1: hys = 10;
      2'h2: hys = 25;
      2'h3: hys = 50;
      default: hys = 0;
    endcase
    if (!cfg_i.enable)
      cmp_o = ~cmp_o;
    else if (pos_mv_i > neg + hys)
      cmp_o = 1'b1;
    else if (pos_mv_i <= neg - hys)
      cmp_o = 1'b0;
  end
endmodule

// ### bench/testbench.sv
// self-checking bench for the comparator control
// assumes the core model beside it and a 100 MHz clock
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [7:0] reg_rdata_o;
  acc_pkg::acc_sleep_t sleep_mode_i = acc_pkg::acc_active;
  logic clk_req_other_i = 1'b0;
  logic cmp_raw_i;
  acc_pkg::acc_analog_t analog_cfg_o;
  logic event_o, pin_out_o, pin_oe_n_o, irq_o;
  int pos_mv = 400; // analog levels fed to the core
  int neg_mv = 500;
  int vref_mv = 300;
  int fail_count = 0;
  int checked = 0;
  int p, n;
  logic [7:0] exp_q[$]; // expected read data, oldest first
  logic rd_seen = 1'b0; // read strobe taken at last edge

  always #5 ref_clk_i = ~ref_clk_i;

  acc_ctl u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .sleep_mode_i(sleep_mode_i),
    .clk_req_other_i(clk_req_other_i), .cmp_raw_i(cmp_raw_i),
    .analog_cfg_o(analog_cfg_o), .event_o(event_o),
    .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .irq_o(irq_o));

  acc_core_model u_core (.cfg_i(analog_cfg_o), .pos_mv_i(pos_mv),
    .neg_mv_i(neg_mv), .vref_mv_i(vref_mv), .cmp_o(cmp_raw_i));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // settle past the edge so registered outputs have landed
  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_write_i <= 1'b0;
  endtask

  // read data is judged by the watcher one cycle later
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk_i);
    reg_read_i <= 1'b0;
  endtask

  always @(posedge ref_clk_i)
    rd_seen <= reg_read_i;
  always @(negedge ref_clk_i)
    if (rd_seen)
      chk(reg_rdata_o, exp_q.pop_front());

  // move the raw result, then wait out the synchroniser
  task automatic cmp_to(input logic v);
    @(posedge ref_clk_i);
    pos_mv <= v ? 600 : 400;
    wt(6);
  endtask

  task automatic edge_case(input logic [1:0] m, input logic v);
    logic e;
    e = (m == 2'h0) || (m == 2'h3 && v) || (m == 2'h2 && !v);
    cmp_to(!v);
    wr(3'h0, {2'h1, m, 4'h1});
    wr(3'h7, 8'h01);
    wt(2);
    chk(irq_o, 1'b0);
    cmp_to(v);
    chk(irq_o, e);
    rd(3'h7, {3'h0, v, 3'h0, e});
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #300000;
    fail_count++;
    report_and_stop();
  end

  initial
  begin
    void'($urandom(50));
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    wt(1);
    chk(pin_oe_n_o, 1'b1);
    chk(event_o, 1'b0);
    for (int a = 0; a < 8; a++)
      rd(3'(a), 8'h00);
    wr(3'h0, 8'hfe);
    rd(3'h0, 8'hf6);
    wr(3'h2, 8'hff);
    rd(3'h2, 8'h8b);
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h01);
    wr(3'h1, 8'hff);
    rd(3'h1, 8'h00);
    wt(1);
    chk({2'h0, analog_cfg_o}, 8'h1f);
    for (int h = 0; h < 4; h++)
    begin
      wr(3'h0, {5'h0, 2'(h), 1'b0});
      wt(1);
      chk(analog_cfg_o.hysteresis_select, 8'(h));
    end
    wr(3'h6, 8'h00);
    $display("test registers done");
    // inputs first, then pin and enable; reserved edge code
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h50);
    wr(3'h0, 8'h51);
    wt(250);
    chk(pin_oe_n_o, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      p = $urandom_range(1000);
      n = $urandom_range(1000);
      @(posedge ref_clk_i);
      pos_mv <= p;
      neg_mv <= n;
      wt(6);
      chk(event_o, p > n);
      chk(pin_out_o, p > n);
      rd(3'h7, {3'h0, p > n, 4'h0});
    end
    wr(3'h0, 8'h11);
    wt(1);
    chk(pin_oe_n_o, 1'b1);
    @(posedge ref_clk_i);
    pos_mv <= 400;
    neg_mv <= 900;
    wr(3'h2, 8'h02);
    wt(6000);
    chk(event_o, 1'b1);
    wr(3'h2, 8'h80);
    cmp_to(1'b0);
    chk(event_o, 1'b1);
    rd(3'h7, 8'h10);
    @(posedge ref_clk_i);
    neg_mv <= 500;
    cmp_to(1'b1);
    chk(pin_out_o, 1'b0);
    rd(3'h7, 8'h00);
    wr(3'h2, 8'h00);
    $display("test compare done");
    wr(3'h6, 8'h01);
    for (int i = 0; i < 8; i++)
      edge_case(2'(i >> 1), i[0]);
    wr(3'h6, 8'h00);
    wt(1);
    chk(irq_o, 1'b0);
    wr(3'h6, 8'h01);
    wt(1);
    chk(irq_o, 1'b1);
    wr(3'h7, 8'h00);
    wt(1);
    chk(irq_o, 1'b1);
    wr(3'h7, 8'h01);
    wt(1);
    chk(irq_o, 1'b0);
    $display("test edges done");
    @(posedge ref_clk_i);
    sleep_mode_i <= acc_pkg::acc_idle;
    edge_case(2'h0, 1'b0);
    wr(3'h7, 8'h01);
    wr(3'h0, 8'hf1);
    @(posedge ref_clk_i);
    sleep_mode_i <= acc_pkg::acc_standby;
    wt(2);
    chk(analog_cfg_o.enable, 1'b1);
    cmp_to(1'b1);
    chk(event_o, 1'b1);
    chk(pin_out_o, 1'b1);
    chk(irq_o, 1'b0);
    rd(3'h7, 8'h00);
    // another module asks for the clock: status catches up
    clk_req_other_i <= 1'b1;
    wt(6);
    chk(irq_o, 1'b1);
    rd(3'h7, 8'h11);
    wr(3'h7, 8'h01);
    clk_req_other_i <= 1'b0;
    wr(3'h0, 8'h71);
    wt(2);
    chk(analog_cfg_o.enable, 1'b0);
    chk(pin_oe_n_o, 1'b1);
    @(posedge ref_clk_i);
    sleep_mode_i <= acc_pkg::acc_pwrdown;
    wr(3'h0, 8'hf1);
    wt(2);
    chk(analog_cfg_o.enable, 1'b0);
    chk(pin_oe_n_o, 1'b1);
    chk(event_o, 1'b0);
    @(posedge ref_clk_i);
    sleep_mode_i <= acc_pkg::acc_active;
    wt(8);
    $display("test sleep done");
    report_and_stop();
  end
endmodule
